//--- rtl/spi_flash_wrap_program_erase.sv
// Purpose: Wrap setup, page program and sector erase command logic
// Assumes: Pins synchronised here; status inputs on the system clock
// Notes: Array writes and erases leave as pulses with address and data
`timescale 1ns/1ps
`include "flash_seq_cfg.svh"

// Contract
// - Wrap command: opcode, 24 dummy, parameter byte
// - Ignore parameter bits 7 and 3..0
// - Bit 4 zero wraps, one reads linearly
// - Bits 6..5 pick 8/16/32/64 byte section
// - Wrapping read stays in aligned section
// - Wrap setting persists until next wrap command
// - Wrap disabled after power-on
// - Quad read uses four lanes, four dummies
// - Page program: opcode, address, data, single lane
// - Page program needs write enable latch
// - Program address rolls within the page
// - Program only if select rises on byte boundary
// - Busy high during program, status still readable
// - Program end clears write enable latch
// - No program into protected page
// - Quad program needs quad enable and latch
// - Sector erase sets 4 KB to ones
// - Erase only if select rises after address
// - Busy high during erase, low after
// - Erase end clears write enable latch
// - No erase of protected sector
module spi_flash_wrap_program_erase
    import flash_seq_pkg::*;
#(
    parameter int PROG_CYC = `PROG_CYC,
    parameter int ERASE_CYC = `ERASE_CYC
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic [3:0] i_quad_data_lanes,
    input wire logic i_wel_set,
    input wire logic i_quad_enable_bit,
    input wire logic [2:0] i_protect_range_bits,
    input wire logic i_protect_top_bottom_bit,
    input wire logic i_protect_granularity_bit,
    input wire logic i_protect_complement_bit,
    input wire logic [23:0] i_rd_addr,
    output logic o_busy,
    output logic o_write_enable_latch,
    output logic o_wrap_disable_bit,
    output logic [1:0] o_wrap_length_field,
    output logic [23:0] o_rd_next_addr,
    output logic o_arr_wr,
    output logic o_arr_erase,
    output logic [23:0] o_arr_addr,
    output logic [7:0] o_arr_data
);

    localparam logic [23:0] PROG_TMR = 24'(PROG_CYC - 1);
    localparam logic [23:0] ERASE_TMR = 24'(ERASE_CYC - 1);

    typedef struct packed {
        seq_type seq;
        phase_type ph;
        logic [7:0] op;
        logic [4:0] bits;
        logic [31:0] sh;
        logic [23:0] addr;
        logic [7:0] idx;
        logic byte_ok;
        logic [255:0] vld;
        logic [8:0] walk;
        logic [7:0] widx;
        logic wvld;
        logic [23:0] tmr;
        logic write_enable_latch;
        logic wdis;
        logic [1:0] wlen;
        logic [23:0] nxt_rd;
        logic arr_wr;
        logic arr_er;
        logic [23:0] arr_addr;
        logic [7:0] arr_data;
    } st_type;

    st_type st_r;
    st_type st_nxt;

    spi_samp_if samp ();

    logic busy;
    logic hit_now;
    logic prog_go;
    logic erase_go;
    logic quad;
    logic wrap_load;
    logic data_done;
    logic [31:0] sh_new;
    logic [4:0] bits_new;
    logic buf_we;
    logic [7:0] buf_waddr;
    logic [7:0] buf_wdata;
    logic [7:0] buf_raddr;
    logic [7:0] buf_rdata;

    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------
    function automatic logic prot_hit(input logic [23:0] a, input logic [2:0] bp, input logic tb,
                                      input logic sec, input logic cmp);
        logic [22:0] size;
        logic [22:0] off;
        logic hit;
        off = {2'b00, a[20:0]};
        if (bp == 3'd0) begin
            size = 23'h000000;
        end else if (sec) begin
            size = (bp >= 3'd4) ? `PROT_SEC_MAX : (`PROT_SEC << (bp - 3'd1));
        end else begin
            size = (bp >= 3'd6) ? `FLASH_BYTES : (`PROT_BLK << (bp - 3'd1));
        end
        hit = tb ? (off < size) : ((size != 23'h000000) && (off >= (`FLASH_BYTES - size)));
        return hit ^ cmp;
    endfunction

    function automatic logic [23:0] wrap_next(input logic [23:0] a, input logic dis, input logic [1:0] len);
        logic [23:0] m;
        logic [23:0] inc;
        m = (`WRAP_MIN_BYTES << len) - 24'h000001;
        inc = a + 24'h000001;
        return dis ? inc : ((a & ~m) | (inc & m));
    endfunction

    function automatic logic known_op(input logic [7:0] op);
        return (op == `OP_SET_WRAP) || (op == `OP_PAGE_PROG) || (op == `OP_QUAD_PROG) || (op == `OP_SECT_ERASE);
    endfunction

    // ----------------------------------------
    // Pins and page buffer
    // ----------------------------------------
    spi_pin_sync u_sync (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_sclk(i_sclk),
        .i_cs_n(i_cs_n),
        .i_lanes(i_quad_data_lanes),
        .o_samp(samp.src)
    );

    page_buf u_buf (
        .i_sys_clk(i_sys_clk),
        .i_we(buf_we),
        .i_waddr(buf_waddr),
        .i_wdata(buf_wdata),
        .i_raddr(buf_raddr),
        .o_rdata(buf_rdata)
    );

    // ----------------------------------------
    // Acceptance at select rise
    // ----------------------------------------
    assign busy = (st_r.seq != S_IDLE);
    assign hit_now = prot_hit(st_r.addr, i_protect_range_bits, i_protect_top_bottom_bit,
                              i_protect_granularity_bit, i_protect_complement_bit);
    assign prog_go = samp.cs_rise && !busy && st_r.write_enable_latch && !hit_now && (st_r.ph == PH_DATA) && st_r.byte_ok
        && ((st_r.op == `OP_PAGE_PROG) || ((st_r.op == `OP_QUAD_PROG) && i_quad_enable_bit));
    assign erase_go = samp.cs_rise && !busy && st_r.write_enable_latch && !hit_now && (st_r.ph == PH_END)
        && st_r.byte_ok && (st_r.op == `OP_SECT_ERASE);

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        st_nxt = st_r;
        buf_we = 1'b0;
        buf_waddr = st_r.idx;
        buf_wdata = 8'h00;
        buf_raddr = st_r.walk[7:0];
        wrap_load = 1'b0;
        data_done = 1'b0;
        st_nxt.arr_wr = 1'b0;
        st_nxt.arr_er = 1'b0;
        quad = (st_r.ph != PH_OPC) && ((st_r.op == `OP_QUAD_PROG) || (st_r.op == `OP_SET_WRAP));
        sh_new = quad ? {st_r.sh[27:0], samp.lanes} : {st_r.sh[30:0], samp.lanes[0]};
        bits_new = st_r.bits + (quad ? 5'd4 : 5'd1);
        if (samp.cs_fall) begin
            st_nxt.ph = busy ? PH_IGN : PH_OPC;
            st_nxt.bits = 5'd0;
            st_nxt.byte_ok = 1'b0;
        end else if (samp.sclk_rise && samp.cs_low && !busy) begin
            st_nxt.sh = sh_new;
            st_nxt.bits = bits_new;
            unique case (st_r.ph)
                PH_OPC: begin
                    if (bits_new == `BYTE_BITS_N) begin
                        st_nxt.op = sh_new[7:0];
                        st_nxt.bits = 5'd0;
                        st_nxt.ph = known_op(sh_new[7:0]) ? PH_ADDR : PH_IGN;
                        st_nxt.vld = '0;
                    end
                end
                PH_ADDR: begin
                    if (bits_new == `ADDR_BITS_N) begin
                        st_nxt.addr = sh_new[23:0];
                        st_nxt.idx = sh_new[7:0];
                        st_nxt.bits = 5'd0;
                        st_nxt.byte_ok = (st_r.op == `OP_SECT_ERASE);
                        if (st_r.op == `OP_SECT_ERASE) begin
                            st_nxt.ph = PH_END;
                        end else if (st_r.op == `OP_SET_WRAP) begin
                            st_nxt.ph = PH_WRAP;
                        end else begin
                            st_nxt.ph = PH_DATA;
                        end
                    end
                end
                PH_WRAP: begin
                    if (bits_new == `BYTE_BITS_N) begin
                        wrap_load = 1'b1;
                        st_nxt.wdis = sh_new[`WRAP_DIS_POS];
                        st_nxt.wlen = sh_new[`WRAP_LEN_HI:`WRAP_LEN_LO];
                        st_nxt.ph = PH_END;
                        st_nxt.byte_ok = 1'b1;
                    end
                end
                PH_DATA: begin
                    st_nxt.byte_ok = 1'b0;
                    if (bits_new == `BYTE_BITS_N) begin
                        data_done = 1'b1;
                        buf_we = 1'b1;
                        buf_wdata = sh_new[7:0];
                        st_nxt.vld[st_r.idx] = 1'b1;
                        st_nxt.idx = st_r.idx + 8'h01;
                        st_nxt.bits = 5'd0;
                        st_nxt.byte_ok = 1'b1;
                    end
                end
                PH_END: begin
                    st_nxt.ph = PH_IGN;
                    st_nxt.byte_ok = 1'b0;
                end
                PH_IGN: begin
                    st_nxt.bits = 5'd0;
                end
            endcase
        end
        if (samp.cs_rise) begin
            st_nxt.ph = PH_IGN;
            st_nxt.byte_ok = 1'b0;
        end
        unique case (st_r.seq)
            S_IDLE: begin
                st_nxt.walk = 9'h000;
                st_nxt.wvld = 1'b0;
                if (prog_go) begin
                    st_nxt.seq = S_PROG;
                end else if (erase_go) begin
                    st_nxt.seq = S_ERASE;
                    st_nxt.arr_er = 1'b1;
                    st_nxt.arr_addr = st_r.addr & `SECTOR_MASK;
                end
            end
            S_PROG: begin
                st_nxt.arr_wr = st_r.wvld;
                st_nxt.arr_data = buf_rdata;
                st_nxt.arr_addr = {st_r.addr[23:8], st_r.widx};
                st_nxt.widx = st_r.walk[7:0];
                st_nxt.wvld = (st_r.walk != `WALK_END) && st_r.vld[st_r.walk[7:0]];
                st_nxt.walk = st_r.walk + 9'h001;
                if (st_r.walk == `WALK_END) begin
                    st_nxt.seq = S_WAIT;
                    st_nxt.tmr = PROG_TMR;
                end
            end
            S_ERASE: begin
                st_nxt.seq = S_WAIT;
                st_nxt.tmr = ERASE_TMR;
            end
            S_WAIT: begin
                if (st_r.tmr == 24'h000000) begin
                    st_nxt.seq = S_IDLE;
                    st_nxt.write_enable_latch = 1'b0;
                end else begin
                    st_nxt.tmr = st_r.tmr - 24'h000001;
                end
            end
        endcase
        if (i_wel_set && (!busy || (st_nxt.seq == S_IDLE))) begin
            st_nxt.write_enable_latch = 1'b1;
        end
        st_nxt.nxt_rd = wrap_next(i_rd_addr, st_r.wdis, st_r.wlen);
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_r <= '0;
            st_r.seq <= S_IDLE;
            st_r.ph <= PH_IGN;
            st_r.wdis <= `WRAP_DIS_RST;
            st_r.wlen <= `WRAP_LEN_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign o_busy = busy;
    assign o_write_enable_latch = st_r.write_enable_latch;
    assign o_wrap_disable_bit = st_r.wdis;
    assign o_wrap_length_field = st_r.wlen;
    assign o_rd_next_addr = st_r.nxt_rd;
    assign o_arr_wr = st_r.arr_wr;
    assign o_arr_erase = st_r.arr_er;
    assign o_arr_addr = st_r.arr_addr;
    assign o_arr_data = st_r.arr_data;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_n);

    sequence s_walk_busy;
        (o_busy && !o_arr_erase) [*8];
    endsequence

    sequence s_erase_start;
        o_arr_erase && o_busy ##1 !o_arr_erase && o_busy;
    endsequence

    a_walk_busy: assert property (prog_go |=> s_walk_busy)
        else $error("busy not held after program start");

    a_erase_base: assert property (erase_go |=> s_erase_start ##0 (o_arr_addr[11:0] == 12'h000))
        else $error("erase pulse or sector base wrong");

    a_wel_clear: assert property (($fell(o_busy) && !$past(i_wel_set)) |-> !o_write_enable_latch)
        else $error("latch still set after cycle end");

    a_qpp_qe: assert property ((samp.cs_rise && st_r.op == `OP_QUAD_PROG && !i_quad_enable_bit && !busy)
        |=> !o_busy)
        else $error("quad program started without quad enable");
    a_wel_gate: assert property ((samp.cs_rise && !busy && !st_r.write_enable_latch) |=> !o_busy)
        else $error("command started without write enable");

    a_protect_quiet: assert property ((samp.cs_rise && !busy && hit_now) |=> !o_busy && !o_arr_erase)
        else $error("protected region touched");
    a_cs_misplaced: assert property ((samp.cs_rise && !busy && st_r.ph == PH_DATA && !st_r.byte_ok)
        |=> !o_busy)
        else $error("program ran after misplaced select rise");
    a_erase_exact: assert property ((samp.cs_rise && st_r.op == `OP_SECT_ERASE
        && st_r.ph != PH_END && !busy) |=> !o_busy)
        else $error("erase ran after misplaced select rise");

    a_reject_quiet: assert property ((samp.cs_rise && !busy && !prog_go && !erase_go && !i_wel_set)
        |=> !o_busy && $stable(o_write_enable_latch) && !o_arr_wr)
        else $error("rejected command changed state");

    a_wrap_field: assert property (wrap_load |=> (o_wrap_disable_bit == $past(sh_new[4]))
        && (o_wrap_length_field == $past(sh_new[6:5])))
        else $error("wrap parameter stored wrongly");

    a_wrap_hold: assert property (!wrap_load |=> $stable({o_wrap_disable_bit, o_wrap_length_field}))
        else $error("wrap setting changed without command");

    a_wrap_section: assert property (!o_wrap_disable_bit |=> o_rd_next_addr[23:6] == $past(i_rd_addr[23:6]))
        else $error("wrapped read left its section");

    a_linear_read: assert property (o_wrap_disable_bit |=> o_rd_next_addr == $past(i_rd_addr) + 24'h000001)
        else $error("linear read address wrong");

    a_page_roll: assert property (data_done |=> st_r.idx == $past(st_r.idx) + 8'h01)
        else $error("page index did not roll");

endmodule // spi_flash_wrap_program_erase

//--- inc/flash_seq_cfg.svh
// Purpose: Constants of the flash command sequencer
// Assumes: Included by its bare name
// Notes: Opcodes, field positions, reset values, timing
`ifndef FLASH_SEQ_CFG_SVH
`define FLASH_SEQ_CFG_SVH

// ----------------------------------------
// Opcodes
// ----------------------------------------
`define OP_SET_WRAP 8'h77
`define OP_PAGE_PROG 8'h02
`define OP_QUAD_PROG 8'h32
`define OP_SECT_ERASE 8'h20

// ----------------------------------------
// Field positions and bit counts
// ----------------------------------------
`define WRAP_DIS_POS 4
`define WRAP_LEN_HI 6
`define WRAP_LEN_LO 5
`define WRAP_DIS_RST 1'b1
`define WRAP_LEN_RST 2'b00
`define WRAP_MIN_BYTES 24'h000008
`define BYTE_BITS_N 5'd8
`define ADDR_BITS_N 5'd24
`define PAGE_WORDS 256
`define WALK_END 9'h100
`define SECTOR_MASK 24'hfff000

// ----------------------------------------
// Protection geometry
// ----------------------------------------
`define FLASH_BYTES 23'h200000
`define PROT_BLK 23'h010000
`define PROT_SEC 23'h001000
`define PROT_SEC_MAX 23'h008000

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_MHZ 200
`define PROG_TIME_US 400
`define ERASE_TIME_US 45000
`define PROG_CYC (`PROG_TIME_US * `CLK_MHZ)
`define ERASE_CYC (`ERASE_TIME_US * `CLK_MHZ)

`endif

//--- inc/flash_seq_pkg.sv
// Purpose: Types of the flash command sequencer
// Assumes: Nothing
// Notes: Constants live in flash_seq_cfg.svh
package flash_seq_pkg;

    typedef enum logic [2:0] {
        PH_OPC = 3'b000,
        PH_ADDR = 3'b001,
        PH_DATA = 3'b011,
        PH_WRAP = 3'b101,
        PH_END = 3'b111,
        PH_IGN = 3'b100
    } phase_type;

    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_PROG = 2'b01,
        S_WAIT = 2'b11,
        S_ERASE = 2'b10
    } seq_type;

endpackage

//--- inc/spi_samp_if.sv
// Purpose: Sampled SPI pin events between sync and sequencer
// Assumes: One system clock
// Notes: Levels and lanes are registered in the source; edges are gated from registers
`timescale 1ns/1ps
interface spi_samp_if;
    logic cs_low;
    logic cs_rise;
    logic cs_fall;
    logic sclk_rise;
    logic [3:0] lanes;
    modport src (output cs_low, output cs_rise, output cs_fall, output sclk_rise, output lanes);
    modport dst (input cs_low, input cs_rise, input cs_fall, input sclk_rise, input lanes);
endinterface

//--- rtl/spi_pin_sync.sv
// Purpose: Synchronise SPI pins and find clock and select edges
// Assumes: Serial clock far slower than system clock
// Notes: Lanes are delayed like the clock so samples align
`timescale 1ns/1ps
module spi_pin_sync (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic [3:0] i_lanes,
    spi_samp_if.src o_samp
);

    typedef struct packed {
        logic [5:0] s1;
        logic [5:0] s2;
        logic cs_q;
        logic sclk_q;
    } sync_type;

    sync_type st_r;
    sync_type st_nxt;

    // ----------------------------------------
    // Two-stage sync and edge history
    // ----------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = {i_cs_n, i_sclk, i_lanes};
        st_nxt.s2 = st_r.s1;
        st_nxt.cs_q = st_r.s2[5];
        st_nxt.sclk_q = st_r.s2[4];
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_r <= '{s1: 6'h20, s2: 6'h20, cs_q: 1'b1, sclk_q: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_samp.cs_low = ~st_r.s2[5];
    assign o_samp.cs_rise = st_r.s2[5] & ~st_r.cs_q;
    assign o_samp.cs_fall = ~st_r.s2[5] & st_r.cs_q;
    assign o_samp.sclk_rise = st_r.s2[4] & ~st_r.sclk_q;
    assign o_samp.lanes = st_r.s2[3:0];

endmodule // spi_pin_sync

//--- rtl/page_buf.sv
// Purpose: One-page data buffer for program commands
// Assumes: Single clock, one write and one read port
// Notes: Read data come out of a register, one cycle late
`timescale 1ns/1ps
`include "flash_seq_cfg.svh"
module page_buf (
    input wire logic i_sys_clk,
    input wire logic i_we,
    input wire logic [7:0] i_waddr,
    input wire logic [7:0] i_wdata,
    input wire logic [7:0] i_raddr,
    output logic [7:0] o_rdata
);

    logic [7:0] mem [0:`PAGE_WORDS-1];

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        o_rdata <= mem[i_raddr];
    end

endmodule // page_buf

//--- verification/spi_host_model.sv
// Purpose: Host SPI controller model driving select, clock and lanes
// Assumes: Mode 0, serial clock still between frames
// Notes: Released lanes show the inverse of their last value
`timescale 1ns/1ps
module spi_host_model (
    output logic o_sclk,
    output logic o_cs_n,
    output logic [3:0] o_lanes
);
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_lanes = 4'h0;
    end
    // ----------------------------------------
    // Frame tasks
    // ----------------------------------------
    // Shift n bits msb first, w lanes a clock, select held low
    task automatic shift(input logic [31:0] v, input int n, input int w);
        int i;
        logic [31:0] t;
        o_cs_n = 1'b0;
        for (i = n; i > 0; i = i - w) begin
            t = v >> (i - w);
            o_lanes = (w == 4) ? t[3:0] : {~o_lanes[3:1], t[0]};
            #32 o_sclk = 1'b1;
            #32 o_sclk = 1'b0;
        end
    endtask
    // Raise select, release lanes
    task automatic finish;
        #8 o_cs_n = 1'b1;
        o_lanes = ~o_lanes;
        #30;
    endtask
endmodule // spi_host_model

//--- verification/spi_flash_wrap_program_erase_bench.sv
// Purpose: Self-checking bench of wrap setup, program and erase
// Assumes: Short program and erase times through parameters
// Notes: Host model drives the SPI pins
`timescale 1ns/1ps
module spi_flash_wrap_program_erase_bench;
    logic i_sys_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic sclk, cs_n, busy, write_enable_latch, wdis, arr_wr, arr_erase;
    logic wel_set = 1'b0;
    logic qe = 1'b0;
    logic [3:0] lanes;
    logic [2:0] bp = 3'h0;
    logic [2:0] pmode = 3'h0; // Top-bottom, granularity, complement
    logic [1:0] wlen;
    logic [23:0] rd_addr = 24'h000000;
    logic [23:0] nxt, arr_addr, ea;
    logic [7:0] arr_data;
    logic [31:0] wq[$];
    int mismatches = 0;
    int cmp_count = 0;
    int ec = 0;
    int l;
    always #2.5 i_sys_clk = ~i_sys_clk;
    spi_host_model host (.o_sclk(sclk), .o_cs_n(cs_n), .o_lanes(lanes));
    spi_flash_wrap_program_erase #(.PROG_CYC(20), .ERASE_CYC(30)) uut (
        .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_sclk(sclk), .i_cs_n(cs_n),
        .i_quad_data_lanes(lanes), .i_wel_set(wel_set), .i_quad_enable_bit(qe),
        .i_protect_range_bits(bp), .i_protect_top_bottom_bit(pmode[2]),
        .i_protect_granularity_bit(pmode[1]), .i_protect_complement_bit(pmode[0]),
        .i_rd_addr(rd_addr), .o_busy(busy), .o_write_enable_latch(write_enable_latch),
        .o_wrap_disable_bit(wdis), .o_wrap_length_field(wlen), .o_rd_next_addr(nxt),
        .o_arr_wr(arr_wr), .o_arr_erase(arr_erase), .o_arr_addr(arr_addr), .o_arr_data(arr_data));
    always @(negedge i_sys_clk) begin
        if (arr_wr === 1'b1) wq.push_back({arr_addr, arr_data});
        if (arr_erase === 1'b1) begin
            ec++;
            ea = arr_addr;
        end
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask
    task automatic give_verdict;
        $display("comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic set_wel;
        @(posedge i_sys_clk) #1 wel_set = 1'b1;
        @(posedge i_sys_clk) #1 wel_set = 1'b0;
    endtask
    task automatic cmd(input logic [7:0] o, input logic [23:0] a, input logic [31:0] d, input int n, input int w);
        host.shift({24'h0, o}, 8, 1);
        host.shift({8'h0, a}, 24, w);
        host.shift(d, n, w);
        host.finish;
    endtask
    // Busy must rise or stay low, then fall; latch checked after
    task automatic op(input logic exp, input logic ew);
        int n;
        logic seen;
        seen = 1'b0;
        for (n = 0; n < 12; n++) begin
            @(negedge i_sys_clk);
            seen = seen | busy;
        end
        check("busy", {31'h0, exp}, {31'h0, seen});
        for (n = 0; n < 600 && busy !== 1'b0; n++) @(negedge i_sys_clk);
        check("busy end", 32'h0, {31'h0, busy});
        check("latch", {31'h0, ew}, {31'h0, write_enable_latch});
    endtask
    task automatic rd(input logic [23:0] a, input logic [23:0] exp);
        @(posedge i_sys_clk) #1 rd_addr = a;
        @(posedge i_sys_clk);
        @(negedge i_sys_clk) check("next addr", {8'h0, exp}, {8'h0, nxt});
    endtask
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        #150us;
        mismatches++;
        give_verdict;
    end
    initial begin
        repeat (5) @(posedge i_sys_clk);
        #1 i_rst_n = 1'b1;
        repeat (4) @(negedge i_sys_clk);
        check("reset", 32'h4, {busy, write_enable_latch, wdis, wlen});
        rd(24'h0000ff, 24'h000100);
        for (l = 0; l < 4; l++) begin
            cmd(8'h77, 24'h0, {24'h0, 1'b1, l[1:0], 1'b0, 4'hf}, 8, 4);
            check("wrap", {30'h0, l[1:0]}, {29'h0, wdis, wlen});
            rd(24'h1234c0 + (24'h8 << l) - 24'h1, 24'h1234c0);
        end
        cmd(8'h02, 24'h0102fe, 32'ha1b2c3, 24, 1);
        op(1'b0, 1'b0);
        set_wel;
        wq.delete();
        cmd(8'h02, 24'h0102fe, 32'ha1b2c3, 24, 1);
        op(1'b1, 1'b0);
        check("writes", 32'h3, wq.size());
        check("write 0", 32'h010200c3, wq[0]);
        check("write 1", 32'h0102fea1, wq[1]);
        check("write 2", 32'h0102ffb2, wq[2]);
        rd(24'h3f01ff, 24'h3f01c0);
        set_wel;
        cmd(8'h02, 24'h000000, 32'ha1b, 12, 1);
        op(1'b0, 1'b1);
        cmd(8'h32, 24'h000010, 32'h5a, 8, 4);
        op(1'b0, 1'b1);
        @(posedge i_sys_clk) #1 qe = 1'b1;
        wq.delete();
        cmd(8'h32, 24'h000010, 32'h5a, 8, 4);
        op(1'b1, 1'b0);
        check("quad writes", 32'h1, wq.size());
        check("quad write", 32'h0000105a, wq[0]);
        set_wel;
        @(posedge i_sys_clk) #1 bp = 3'h7;
        cmd(8'h02, 24'h000100, 32'h11, 8, 1);
        op(1'b0, 1'b1);
        cmd(8'h20, 24'h012345, 32'h0, 0, 1);
        op(1'b0, 1'b1);
        @(posedge i_sys_clk) #1 {bp, pmode} = 6'h0e;
        cmd(8'h02, 24'h000100, 32'h11, 8, 1);
        op(1'b0, 1'b1);
        @(posedge i_sys_clk) #1 {bp, pmode} = 6'h01;
        cmd(8'h20, 24'h012345, 32'h0, 0, 1);
        op(1'b0, 1'b1);
        @(posedge i_sys_clk) #1 {bp, pmode} = 6'h00;
        cmd(8'h20, 24'h012345, 32'h1, 1, 1);
        op(1'b0, 1'b1);
        check("erase count", 32'h0, ec);
        cmd(8'h20, 24'h012345, 32'h0, 0, 1);
        op(1'b1, 1'b0);
        check("erase", 32'h1012000, {ec[7:0], ea});
        cmd(8'h77, 24'h0, 32'h10, 8, 4);
        check("wrap off", 32'h4, {29'h0, wdis, wlen});
        rd(24'h0102ff, 24'h010300);
        give_verdict;
    end
endmodule // spi_flash_wrap_program_erase_bench
